//--- logic/dmc_channel_ctrl.sv
// per-channel control and addressing setup for a four-channel dma controller
`timescale 1ns/1ps
module dmc_channel_ctrl
   import dmc_pkg::*;
(
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire dmc_bus_t                     bus,
   output logic [7:0]                        bus_rdata,
   output logic                              bus_rack,
   input  wire logic [NCH-1:0]               hw_trig,
   input  wire logic [NCH-1:0]               xfer_last,
   input  wire logic [NCH-1:0][ADDR_W-1:0]   src_addr_in,
   input  wire logic [NCH-1:0][ADDR_W-1:0]   dst_addr_in,
   output dmc_req_t                          req,
   output logic                              req_valid,
   input  wire logic                         req_ready,
   output logic [NCH-1:0]                    chan_enable,
   output logic [NCH-1:0]                    chan_init,
   output logic [NCH-1:0]                    chan_wide
);

   // one-hot channel select for register base + 2*n + off
   function automatic logic [NCH-1:0] chan_hit(input logic [7:0] a,
                                               input logic [7:0] base,
                                               input int off);
      logic [NCH-1:0] h;
      h = '0;
      for (int i = 0; i < NCH; i++)
         h[i] = (a == base + 8'(2 * i + off));
      return h;
   endfunction

   // byte write touches every bit, bit write only the selected one
   function automatic logic wr_hits(input dmc_bus_t b, input int pos);
      return b.wr & (~b.bit_acc | (b.bit_sel == 3'(pos)));
   endfunction

   function automatic logic wr_val(input dmc_bus_t b, input int pos);
      return b.bit_acc ? b.wdata[0] : b.wdata[pos];
   endfunction

   // the prohibited code is treated as a held address so the engine never sees it
   function automatic dmc_step_t step_of(input logic [1:0] code);
      case (code)
         2'b00:   return DMC_STEP_INC;
         2'b01:   return DMC_STEP_DEC;
         default: return DMC_STEP_FIX;
      endcase
   endfunction

   logic [NCH-1:0]       ctl_hit;
   logic [NCH-1:0]       adrc_lo_hit;
   logic [NCH-1:0]       adrc_hi_hit;
   logic [NCH-1:0]       done_q;
   logic [NCH-1:0]       pend_q;
   logic [NCH-1:0]       init_cmd;
   logic [NCH-1:0]       strig_cmd;
   logic [NCH-1:0]       grant;
   logic [NCH-1:0][15:0] adrc_q;
   logic                 buf_ready;
   logic                 push;
   dmc_req_t             push_req;
   logic [7:0]           rd_val;

   assign ctl_hit     = chan_hit(bus.addr, CTL_BASE, 0);
   assign adrc_lo_hit = chan_hit(bus.addr, ADRC_BASE, 0);
   assign adrc_hi_hit = chan_hit(bus.addr, ADRC_BASE, 1);

   genvar n;
   generate
      for (n = 0; n < NCH; n++)
      begin : g_ch
         // write-only command bits: act on a written one, never stored
         assign init_cmd[n]  = ctl_hit[n] & wr_hits(bus, INIT_BIT)
                               & wr_val(bus, INIT_BIT);
         assign strig_cmd[n] = ctl_hit[n] & wr_hits(bus, STRIG_BIT)
                               & wr_val(bus, STRIG_BIT);
         assign chan_wide[n] = adrc_q[n][WIDTH_BIT];

         always_ff @(posedge ref_clk)
         begin
            if (rst)
               chan_enable[n] <= CTL_RST[EN_BIT];
            else if (init_cmd[n])
               chan_enable[n] <= 1'b0;
            else if (ctl_hit[n] && wr_hits(bus, EN_BIT))
               chan_enable[n] <= wr_val(bus, EN_BIT);
         end

         // completion beats a read-clear in the same cycle
         // so a transfer ending during a status poll is never missed
         always_ff @(posedge ref_clk)
         begin
            if (rst)
               done_q[n] <= CTL_RST[DONE_BIT];
            else if (xfer_last[n])
               done_q[n] <= 1'b1;
            else if (init_cmd[n] || (ctl_hit[n] && bus.rd))
               done_q[n] <= 1'b0;
         end

         always_ff @(posedge ref_clk)
         begin
            if (rst)
               chan_init[n] <= 1'b0;
            else
               chan_init[n] <= init_cmd[n];
         end

         // a trigger waits here while the buffer is full, so none is lost
         always_ff @(posedge ref_clk)
         begin
            if (rst || init_cmd[n])
               pend_q[n] <= 1'b0;
            else if (chan_enable[n] && (strig_cmd[n] || hw_trig[n]))
               pend_q[n] <= 1'b1;
            else if (grant[n])
               pend_q[n] <= 1'b0;
         end

         always_ff @(posedge ref_clk)
         begin
            if (rst)
               adrc_q[n] <= ADRC_RST;
            else
            begin
               // step code 11 is kept as written; only the request reads it as fixed
               for (int b = 0; b < 8; b++)
               begin
                  if (adrc_lo_hit[n] && wr_hits(bus, b) && ADRC_WMASK[b])
                     adrc_q[n][b] <= wr_val(bus, b);
                  if (adrc_hi_hit[n] && wr_hits(bus, b) && ADRC_WMASK[b + 8])
                     adrc_q[n][b + 8] <= wr_val(bus, b);
               end
            end
         end
      end
   endgenerate

   // fixed priority, channel 0 highest; one request per cycle
   always_comb
   begin
      grant    = '0;
      push     = 1'b0;
      push_req = '0;
      for (int i = NCH - 1; i >= 0; i--)
      begin
         if (pend_q[i] && chan_enable[i] && buf_ready)
         begin
            grant    = '0;
            grant[i] = 1'b1;
            push     = 1'b1;
            push_req.chan     = 2'(i);
            push_req.wide     = adrc_q[i][WIDTH_BIT];
            push_req.src_step = step_of(adrc_q[i][SRC_STEP_LO +: 2]);
            push_req.dst_step = step_of(adrc_q[i][DST_STEP_LO +: 2]);
            // wide units never start odd; the engine only ever sees
            // the even address, whatever the address registers hold
            push_req.src_addr = src_addr_in[i]
                                & ~ADDR_W'(adrc_q[i][WIDTH_BIT]);
            push_req.dst_addr = dst_addr_in[i]
                                & ~ADDR_W'(adrc_q[i][WIDTH_BIT]);
         end
      end
   end

   // two request flops let a stalled engine lose no trigger
   // and keep req and req_valid straight from flops
   dmc_buf2 u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (push_req),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .out_data  (req),
      .out_valid (req_valid),
      .out_ready (req_ready)
   );

   // read answer one cycle after the strobe
   // every read is answered, mapped or not, so a master never hangs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         bus_rack <= 1'b0;
      else
         bus_rack <= bus.rd;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         bus_rdata <= 8'h00;
      else if (bus.rd)
         bus_rdata <= bus.bit_acc ? {7'h00, rd_val[bus.bit_sel]} : rd_val;
   end

   // command bits and 6..3 always read zero; unmapped addresses read 00
   always_comb
   begin
      rd_val = 8'h00;
      for (int i = 0; i < NCH; i++)
      begin
         if (ctl_hit[i])
            rd_val = {done_q[i], 6'h00, chan_enable[i]};
         if (adrc_lo_hit[i])
            rd_val = adrc_q[i][7:0];
         if (adrc_hi_hit[i])
            rd_val = adrc_q[i][15:8];
      end
   end

endmodule

//--- logic/dmc_pkg.sv
// shared constants and types for the dma channel setup and control slice
package dmc_pkg;

   localparam int NCH    = 4;
   localparam int ADDR_W = 26;

   // low address byte of each register; channel n sits at base + 2*n
   localparam logic [7:0] CTL_BASE  = 8'he0;
   localparam logic [7:0] ADRC_BASE = 8'hd0;

   // dma_channel_control fields
   localparam int DONE_BIT  = 7;
   localparam int INIT_BIT  = 2;
   localparam int STRIG_BIT = 1;
   localparam int EN_BIT    = 0;
   localparam logic [7:0] CTL_RST  = 8'h00;

   // dma_addressing_control fields
   localparam int WIDTH_BIT   = 14;
   localparam int SRC_STEP_LO = 6;
   localparam int DST_STEP_LO = 4;
   localparam logic [15:0] ADRC_RST   = 16'h0000;
   localparam logic [15:0] ADRC_WMASK = 16'h40f0;

   typedef enum logic [1:0] {
      DMC_STEP_INC = 2'b00,
      DMC_STEP_DEC = 2'b01,
      DMC_STEP_FIX = 2'b10
   } dmc_step_t;

   typedef struct packed {
      logic [1:0]        chan;
      logic              wide;
      dmc_step_t         src_step;
      dmc_step_t         dst_step;
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
   } dmc_req_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bit_acc;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmc_bus_t;

endpackage

//--- logic/dmc_buf2.sv
// two-entry buffer between the request arbiter and the transfer engine
`timescale 1ns/1ps
module dmc_buf2
   import dmc_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     rst,
   input  wire dmc_req_t in_data,
   input  wire logic     in_valid,
   output logic          in_ready,
   output dmc_req_t      out_data,
   output logic          out_valid,
   input  wire logic     out_ready
);

   dmc_req_t slot1_q;
   logic     v1_q;
   logic     push;
   logic     pop;

   // head slot feeds the output directly so the engine sees flop outputs
   assign in_ready = ~v1_q;
   assign push     = in_valid & ~v1_q;
   assign pop      = out_valid & out_ready;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         out_valid <= 1'b0;
         v1_q      <= 1'b0;
      end
      else if (pop)
      begin
         out_valid <= v1_q | push;
         v1_q      <= v1_q & push;
      end
      else if (push)
      begin
         out_valid <= 1'b1;
         v1_q      <= out_valid;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         out_data <= '0;
         slot1_q  <= '0;
      end
      else if (pop)
      begin
         out_data <= v1_q ? slot1_q : in_data;
         if (v1_q && push)
            slot1_q <= in_data;
      end
      else if (push)
      begin
         if (out_valid)
            slot1_q <= in_data;
         else
            out_data <= in_data;
      end
   end

endmodule

//--- bench/dmc_channel_ctrl_sva.sv
// port assertions for the dma channel control slice
`timescale 1ns/1ps
module dmc_ctrl_chk
   import dmc_pkg::*;
(
   input wire logic           ref_clk,
   input wire logic           rst,
   input wire dmc_bus_t       bus,
   input wire logic [7:0]     bus_rdata,
   input wire logic           bus_rack,
   input wire logic [NCH-1:0] hw_trig,
   input wire dmc_req_t       req,
   input wire logic           req_valid,
   input wire logic           req_ready,
   input wire logic [NCH-1:0] chan_enable,
   input wire logic [NCH-1:0] chan_init
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence ctl0_wr_s;
      bus.wr && !bus.bit_acc && bus.addr == CTL_BASE;
   endsequence
   rack_rd_a: assert property (bus.rd |=> bus_rack)
      else $error("read not answered");
   rack_idle_a: assert property (!bus.rd |=> !bus_rack)
      else $error("stray read answer");
   zero_bits_a: assert property (bus_rack && $past(bus.addr[7:4]) == CTL_BASE[7:4]
      |-> bus_rdata[6:1] == 6'h00) else $error("zero bits read nonzero");
   bit_read_a: assert property (bus_rack && $past(bus.bit_acc)
      |-> bus_rdata[7:1] == 7'h00) else $error("bit read upper bits set");
   en_write_a: assert property (ctl0_wr_s |=> chan_enable[0] ==
      ($past(bus.wdata[0]) && !$past(bus.wdata[2]))) else $error("enable not written");
   init_pulse_a: assert property (ctl0_wr_s ##0 bus.wdata[2]
      |=> chan_init[0] ##1 !chan_init[0]) else $error("init pulse wrong");
   even_start_a: assert property (req_valid && req.wide
      |-> !req.src_addr[0] && !req.dst_addr[0]) else $error("wide request at odd address");
   req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req))
      else $error("request dropped while stalled");
   trig_req_a: assert property (hw_trig[0] && chan_enable[0] && !req_valid |-> ##[1:4] req_valid)
      else $error("trigger gave no request");
   rst_clear_a: assert property (disable iff (1'b0) rst |=> bus_rdata == 8'h00 &&
      chan_enable == '0 && !req_valid) else $error("reset state wrong");
endmodule
bind dmc_channel_ctrl dmc_ctrl_chk chk_u (.ref_clk(ref_clk), .rst(rst), .bus(bus),
   .bus_rdata(bus_rdata), .bus_rack(bus_rack), .hw_trig(hw_trig), .req(req),
   .req_valid(req_valid), .req_ready(req_ready), .chan_enable(chan_enable), .chan_init(chan_init));

//--- bench/dmc_engine_model.sv
// transfer engine stand-in: takes requests, stalls on demand, reports completion
`timescale 1ns/1ps
module dmc_engine_model
   import dmc_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst,
   input  wire dmc_req_t  req,
   input  wire logic      req_valid,
   input  wire logic      hold,
   output logic           req_ready,
   output logic [NCH-1:0] xfer_last,
   output logic           got,
   output dmc_req_t       got_req
);
   // a held engine refuses everything, like one busy on a long block
   assign req_ready = !hold;
   always_ff @(posedge ref_clk)
   begin
      got       <= !rst && req_valid && req_ready;
      xfer_last <= '0;
      if (!rst && req_valid && req_ready)
      begin
         got_req   <= req;
         xfer_last <= NCH'(1) << req.chan;
      end
   end
endmodule

//--- bench/dmc_channel_ctrl_bench.sv
// self-checking bench for the dma channel control slice
`timescale 1ns/1ps
module dmc_channel_ctrl_bench
   import dmc_pkg::*;
;
   logic                       ref_clk = 0, rst = 1, hold = 0, rack, req_valid, req_ready, got;
   dmc_bus_t                   b = '0;
   dmc_req_t                   req, gq;
   logic [7:0]                 rdata, rv;
   logic [NCH-1:0]             trig = '0, last, en, init, wide;
   logic [NCH-1:0][ADDR_W-1:0] sa = {NCH{26'h0000123}}, da = {NCH{26'h0000457}};
   int                         n_mismatch = 0, comparisons = 0;
   always #50 ref_clk = !ref_clk;
   dmc_channel_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .bus(b), .bus_rdata(rdata),
      .bus_rack(rack), .hw_trig(trig), .xfer_last(last), .src_addr_in(sa), .dst_addr_in(da),
      .req(req), .req_valid(req_valid), .req_ready(req_ready), .chan_enable(en),
      .chan_init(init), .chan_wide(wide));
   dmc_engine_model eng_u (.ref_clk(ref_clk), .rst(rst), .req(req), .req_valid(req_valid),
      .hold(hold), .req_ready(req_ready), .xfer_last(last), .got(got), .got_req(gq));
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, ba, input logic [2:0] bs, input logic [7:0] a, d);
      @(posedge ref_clk);
      #10 b = {w, !w, ba, bs, a, d};
      @(posedge ref_clk);
      #10 b = '0;
      rv = rdata;
   endtask
   task automatic rdc(input logic ba, input logic [2:0] bs, input logic [7:0] a, e);
      acc(0, ba, bs, a, 8'h00);
      chk(rv, e);
      chk(rack, 1'b1);
   endtask
   task automatic pulse(input logic [NCH-1:0] t);
      @(posedge ref_clk);
      #10 trig = t;
      @(posedge ref_clk);
      #10 trig = '0;
   endtask
   // bounded wait for the engine to take one request
   task automatic wget(input logic [1:0] ch);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge ref_clk);
         #10;
         if (got === 1'b1)
            break;
      end
      chk(got, 1);
      chk(gq.chan, ch);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
      begin
         rdc(0, 0, 8'hd0 + i[7:0], 8'h00);
         rdc(0, 0, 8'he0 + i[7:0], 8'h00);
      end
      rdc(0, 0, 8'h10, 8'h00);
   endtask
   task automatic t_bits;
      acc(1, 0, 0, 8'he0, 8'hf9);
      rdc(0, 0, 8'he0, 8'h01);
      acc(1, 1, 0, 8'he2, 8'h01);
      rdc(1, 0, 8'he2, 8'h01);
      rdc(0, 0, 8'he2, 8'h01);
      rdc(1, 1, 8'he0, 8'h00);
      acc(1, 1, 1, 8'he2, 8'h01);
      wget(1);
   endtask
   task automatic t_steps;
      for (int c = 0; c < 4; c++)
      begin
         // the last request on this channel has completed, so no init first
         acc(1, 0, 0, 8'hd2, {c[1:0], c[1:0], 4'h0});
         acc(1, 0, 0, 8'hd3, 8'h00);
         acc(1, 0, 0, 8'he2, 8'h03);
         wget(1);
         chk(gq.src_step, (c == 3) ? 2'b10 : c[1:0]);
         chk(gq.dst_step, (c == 3) ? 2'b10 : c[1:0]);
         chk({gq.wide, gq.src_addr}, {1'b0, sa[1]});
      end
   endtask
   task automatic t_wide;
      acc(1, 0, 0, 8'hd1, 8'h40);
      chk(wide, 4'h1);
      acc(1, 0, 0, 8'hd0, 8'h00);
      pulse(4'h1);
      wget(0);
      chk({gq.wide, gq.src_addr}, {1'b1, sa[0][25:1], 1'b0});
      chk(gq.dst_addr, {da[0][25:1], 1'b0});
      rdc(0, 0, 8'he0, 8'h81);
      rdc(0, 0, 8'he0, 8'h01);
   endtask
   task automatic t_stall;
      acc(1, 0, 0, 8'he4, 8'h01);
      acc(1, 0, 0, 8'he6, 8'h01);
      hold = 1;
      pulse(4'hc);
      repeat (4) @(posedge ref_clk);
      #10 chk({req_valid, req.chan}, {1'b1, 2'd2});
      hold = 0;
      wget(2);
      wget(3);
   endtask
   task automatic t_init;
      pulse(4'h1);
      wget(0);
      acc(1, 0, 0, 8'he0, 8'h04);
      chk({init, en}, {4'h1, 4'he});
      rdc(0, 0, 8'he0, 8'h00);
      pulse(4'h1);
      repeat (5) @(posedge ref_clk);
      #10 chk(req_valid, 0);
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #10 rst = 0;
      t_reset;
      $display("reset values done");
      t_bits;
      $display("register access done");
      t_steps;
      $display("step codes done");
      t_wide;
      $display("wide start done");
      t_stall;
      $display("stall done");
      t_init;
      $display("init done");
      give_verdict;
   end
   // whole run is under two hundred cycles
   initial
   begin
      #(3000 * 100);
      n_mismatch++;
      give_verdict;
   end
endmodule
